// ### bfp_pkg.sv
// Shared constants and types of the breaker failure supervision block
package bfp_pkg;

	// System clock and millisecond tick
	localparam int unsigned BFP_CLK_HZ = 32'h017D7840;
	localparam int unsigned BFP_TICK_US = 32'h000003E8;
	localparam int unsigned BFP_TICK_CYC = BFP_CLK_HZ / 32'h000F4240 * BFP_TICK_US;

	// Widths
	localparam int BFP_MS_W = 16;
	localparam int BFP_PCT_W = 8;
	localparam int BFP_CUR_W = 16;
	localparam int BFP_NPH = 3;

	// Setting ranges in ms or percent
	localparam logic [15:0] BFP_BACKUP_MIN = 16'h0064;
	localparam logic [15:0] BFP_BACKUP_MAX = 16'hEA60;
	localparam logic [15:0] BFP_PULSE_MAX = 16'hEA60;
	localparam logic [15:0] BFP_RETRIP_MAX = 16'h03E8;
	localparam logic [7:0] BFP_PH_THR_MIN = 8'h14;
	localparam logic [7:0] BFP_RES_THR_MIN = 8'h0A;
	localparam logic [7:0] BFP_THR_MAX = 8'hC8;

	// Operating selector
	typedef enum logic [1:0] {
		BFP_OFF,
		BFP_CURRENT,
		BFP_CONTACT,
		BFP_BOTH
	} bfp_mode_t;

	// Settings word
	typedef struct packed {
		bfp_mode_t mode;
		logic retrip_en;
		logic [7:0] ph_thr;
		logic [7:0] res_thr;
		logic [15:0] retrip_ms;
		logic [15:0] backup_ms;
		logic [15:0] pulse_ms;
	} bfp_cfg_t;

	localparam bfp_cfg_t BFP_CFG_RST = '{
		mode: BFP_OFF,
		retrip_en: 1'h0,
		ph_thr: 8'h1E,
		res_thr: 8'h14,
		retrip_ms: 16'h0064,
		backup_ms: 16'h03E8,
		pulse_ms: 16'h0064
	};

endpackage

// ### bfp_timer.sv
// Backup and retrip timers of one supervised channel
module bfp_timer import bfp_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_tick,
	input wire logic i_enable,
	input wire logic i_start,
	input wire logic i_fault,
	// Delays
	input wire logic [BFP_MS_W-1:0] i_backup_ms,
	input wire logic [BFP_MS_W-1:0] i_retrip_ms,
	// Results
	output logic o_backup_fire,
	output logic o_retrip_fire,
	output logic o_running
);

	logic start_d_r;
	logic run_r;
	logic bu_done_r;
	logic rt_done_r;
	logic [BFP_MS_W-1:0] cnt_r;

	wire logic start_rise = i_start & ~start_d_r;
	wire logic keep = i_enable & i_start & i_fault;
	wire logic cnt_max = &cnt_r;
	wire logic bu_hit = run_r & ~bu_done_r & (cnt_r >= i_backup_ms);
	wire logic rt_hit = run_r & ~rt_done_r & (cnt_r >= i_retrip_ms);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_d_r <= 1'h0;
		end else begin
			start_d_r <= i_start;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_r <= 1'h0;
			cnt_r <= '0;
			bu_done_r <= 1'h0;
			rt_done_r <= 1'h0;
		end else if (!keep) begin // RULE18
			run_r <= 1'h0;
			cnt_r <= '0;
			bu_done_r <= 1'h0;
			rt_done_r <= 1'h0;
		end else if (start_rise) begin // RULE1
			run_r <= 1'h1;
			cnt_r <= '0;
			bu_done_r <= 1'h0;
			rt_done_r <= 1'h0;
		end else begin
			if (run_r && i_tick && !cnt_max) begin // RULE18
				cnt_r <= cnt_r + 1'h1;
			end
			if (bu_hit) begin
				bu_done_r <= 1'h1;
			end
			if (rt_hit) begin
				rt_done_r <= 1'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_backup_fire <= 1'h0;
			o_retrip_fire <= 1'h0;
			o_running <= 1'h0;
		end else begin
			o_backup_fire <= bu_hit & keep; // RULE9
			o_retrip_fire <= rt_hit & keep; // RULE11
			o_running <= run_r;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	fire_once_a: assert property (o_backup_fire |=> !o_backup_fire) // RULE1
		else $error("backup fire repeated");
	timer_clear_a: assert property (!keep |=> !run_r && cnt_r == '0) // RULE18
		else $error("timer not cleared");

endmodule

// ### bfp_pulse.sv
// Trip pulse stretcher with a minimum length in ms
module bfp_pulse import bfp_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_tick,
	input wire logic i_kill,
	input wire logic i_fire,
	input wire logic [BFP_MS_W-1:0] i_pulse_ms,
	// Trip
	output logic o_trip
);

	logic [BFP_MS_W-1:0] left_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_trip <= 1'h0;
			left_r <= '0;
		end else if (i_kill) begin // RULE13
			o_trip <= 1'h0;
			left_r <= '0;
		end else if (i_fire) begin // RULE10
			o_trip <= 1'h1;
			left_r <= i_pulse_ms;
		end else if (o_trip && i_tick) begin
			if (left_r == '0) begin
				o_trip <= 1'h0;
			end else begin
				left_r <= left_r - 1'h1;
			end
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	hold_min_a: assert property (o_trip && left_r != '0 && !i_kill |=> o_trip) // RULE10
		else $error("trip pulse dropped early");

endmodule

// ### bfp_top.sv
// Breaker failure supervision: timers, supervision modes and trip outputs
// What this block does
// RULE1 - Start edge starts backup and retrip timers, separately per phase.
// RULE2 - Other logic gives a general start or three phase starts.
// RULE3 - Selector picks off, current, contact or current-and-contact supervision.
// RULE4 - Current mode ignores breaker contacts; only current comparisons count.
// RULE5 - Contact mode ignores current thresholds; only breaker contacts count.
// RULE6 - Common variant uses one breaker input, single-pole one per phase.
// RULE7 - Combined mode resets only when currents low and breaker open.
// RULE8 - Selector off means no backup trip and no retrip.
// RULE9 - Backup timer expiry with fault still present gives backup trip.
// RULE10 - Every trip lasts at least the pulse duration setting.
// RULE11 - Retrip enabled: phase retrip timer expiry gives that phase's retrip.
// RULE12 - Retrips only in single-pole variant; common gives backup trip only.
// RULE13 - Block input inhibits the function and its trips.
// RULE14 - Backup delay 100 to 60000 ms, default 1000; pulse 0-60000, 100.
// RULE15 - Retrip delay 0 to 1000 ms default 100; retrip off by default.
// RULE16 - Phase threshold 20-200 percent default 30; residual 10-200, 20.
// RULE17 - Residual start input plus per-phase and residual above-threshold flags.
// RULE18 - Timers count a ms tick and clear on start fall or fault loss.
module bfp_top import bfp_pkg::*; #(
	parameter bit SINGLE_POLE = 1'b1,
	parameter int unsigned TICK_CYC = BFP_TICK_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Settings
	input wire logic i_cfg_wr,
	input wire bfp_cfg_t i_cfg,
	// Start requests
	input wire logic i_general_start_request,
	input wire logic i_phase1_start_request,
	input wire logic i_phase2_start_request,
	input wire logic i_phase3_start_request,
	input wire logic i_residual_start_request,
	// Breaker state and blocking
	input wire logic i_breaker_closed_common,
	input wire logic i_breaker_closed_phase1,
	input wire logic i_breaker_closed_phase2,
	input wire logic i_breaker_closed_phase3,
	input wire logic i_block,
	// Current magnitudes in percent of nominal
	input wire logic [BFP_NPH-1:0][BFP_CUR_W-1:0] i_cur_ph,
	input wire logic [BFP_CUR_W-1:0] i_cur_res,
	// Trips
	output logic o_backup_trip_out,
	output logic o_phase1_retrip_out,
	output logic o_phase2_retrip_out,
	output logic o_phase3_retrip_out,
	// Status
	output logic [BFP_NPH-1:0] o_ph_above,
	output logic o_res_above,
	output logic o_running,
	output bfp_cfg_t o_cfg
);

	localparam int NCH = SINGLE_POLE ? BFP_NPH : 1;
	localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

	if (TICK_CYC < 2) begin : g_bad_tick
		$error("TICK_CYC must be at least 2");
	end

	if (BFP_NPH != 3) begin : g_bad_nph
		$error("three phases expected");
	end

	bfp_cfg_t cfg_r;
	bfp_cfg_t cfg_nxt;
	logic [TW-1:0] tick_cnt_r;
	logic tick_r;
	logic [BFP_NPH-1:0] ph_above_r;
	logic res_above_r;
	logic running_r;
	logic [BFP_NPH-1:0] ch_start;
	logic [BFP_NPH-1:0] ch_cur;
	logic [BFP_NPH-1:0] ch_cont;
	logic [BFP_NPH-1:0] ch_fault;
	logic [BFP_NPH-1:0] bu_fire;
	logic [BFP_NPH-1:0] rt_fire;
	logic [BFP_NPH-1:0] ch_run;
	logic [BFP_NPH-1:0] retrip_q;
	logic [BFP_NPH-1:0] ph_above_nxt;

	// Settings clamped to their ranges on write
	wire logic [15:0] wr_backup =
		(i_cfg.backup_ms < BFP_BACKUP_MIN) ? BFP_BACKUP_MIN :
		(i_cfg.backup_ms > BFP_BACKUP_MAX) ? BFP_BACKUP_MAX :
		i_cfg.backup_ms;
	wire logic [15:0] wr_pulse =
		(i_cfg.pulse_ms > BFP_PULSE_MAX) ? BFP_PULSE_MAX : i_cfg.pulse_ms;
	wire logic [15:0] wr_retrip =
		(i_cfg.retrip_ms > BFP_RETRIP_MAX) ? BFP_RETRIP_MAX :
		i_cfg.retrip_ms;
	wire logic [7:0] wr_ph_thr =
		(i_cfg.ph_thr < BFP_PH_THR_MIN) ? BFP_PH_THR_MIN :
		(i_cfg.ph_thr > BFP_THR_MAX) ? BFP_THR_MAX : i_cfg.ph_thr;
	wire logic [7:0] wr_res_thr =
		(i_cfg.res_thr < BFP_RES_THR_MIN) ? BFP_RES_THR_MIN :
		(i_cfg.res_thr > BFP_THR_MAX) ? BFP_THR_MAX : i_cfg.res_thr;

	always_comb begin
		cfg_nxt = i_cfg; // RULE3
		cfg_nxt.backup_ms = wr_backup; // RULE14
		cfg_nxt.pulse_ms = wr_pulse; // RULE14
		cfg_nxt.retrip_ms = wr_retrip; // RULE15
		cfg_nxt.ph_thr = wr_ph_thr; // RULE16
		cfg_nxt.res_thr = wr_res_thr; // RULE16
		cfg_nxt.retrip_en = i_cfg.retrip_en & SINGLE_POLE; // RULE12
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_r <= BFP_CFG_RST; // RULE14 RULE15 RULE16
		end else if (i_cfg_wr) begin
			cfg_r <= cfg_nxt;
		end
	end

	// Millisecond tick
	wire logic tick_wrap = (tick_cnt_r == TW'(TICK_CYC - 1));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_r <= '0;
			tick_r <= 1'h0;
		end else begin
			tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + 1'h1; // RULE18
			tick_r <= tick_wrap;
		end
	end

	// Inhibit by selector or block input
	wire logic inhibit = (cfg_r.mode == BFP_OFF) | i_block; // RULE8 RULE13

	// Current comparators
	wire logic res_above_nxt =
		i_cur_res > {8'h00, cfg_r.res_thr}; // RULE17

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_above_r <= '0;
			res_above_r <= 1'h0;
		end else begin
			ph_above_r <= ph_above_nxt; // RULE17
			res_above_r <= res_above_nxt;
		end
	end

	// Per-channel starts and fault persistence
	wire logic [BFP_NPH-1:0] st_ph = {i_phase3_start_request,
		i_phase2_start_request, i_phase1_start_request};
	wire logic [BFP_NPH-1:0] cb_ph = {i_breaker_closed_phase3,
		i_breaker_closed_phase2, i_breaker_closed_phase1};
	wire logic any_start = i_general_start_request |
		i_residual_start_request | (|st_ph);

	for (genvar p = 0; p < BFP_NPH; p++) begin : g_ch
		assign ph_above_nxt[p] = i_cur_ph[p] > {8'h00, cfg_r.ph_thr};
		if (p < NCH) begin : g_used
			if (SINGLE_POLE) begin : g_sp
				assign ch_start[p] = i_general_start_request |
					i_residual_start_request | st_ph[p]; // RULE2
				assign ch_cur[p] = ph_above_r[p] | res_above_r;
				assign ch_cont[p] = cb_ph[p]; // RULE6
			end else begin : g_cp
				assign ch_start[p] = any_start; // RULE2
				assign ch_cur[p] = (|ph_above_r) | res_above_r;
				assign ch_cont[p] = i_breaker_closed_common; // RULE6
			end
			assign ch_fault[p] =
				(cfg_r.mode == BFP_CURRENT) ? ch_cur[p] : // RULE4
				(cfg_r.mode == BFP_CONTACT) ? ch_cont[p] : // RULE5
				(cfg_r.mode == BFP_BOTH) ? (ch_cur[p] | ch_cont[p]) : // RULE7
				1'h0;

			bfp_timer u_timer (
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_tick(tick_r),
				.i_enable(~inhibit),
				.i_start(ch_start[p]),
				.i_fault(ch_fault[p]),
				.i_backup_ms(cfg_r.backup_ms),
				.i_retrip_ms(cfg_r.retrip_ms),
				.o_backup_fire(bu_fire[p]),
				.o_retrip_fire(rt_fire[p]),
				.o_running(ch_run[p])
			);

			if (SINGLE_POLE) begin : g_rt
				bfp_pulse u_retrip (
					.i_clk(i_clk),
					.i_rst_n(i_rst_n),
					.i_tick(tick_r),
					.i_kill(inhibit),
					.i_fire(rt_fire[p] & cfg_r.retrip_en), // RULE11
					.i_pulse_ms(cfg_r.pulse_ms),
					.o_trip(retrip_q[p])
				);
			end else begin : g_nort
				always_ff @(posedge i_clk or negedge i_rst_n) begin
					if (!i_rst_n) begin
						retrip_q[p] <= 1'h0;
					end else begin
						retrip_q[p] <= 1'h0; // RULE12
					end
				end
			end
		end else begin : g_unused
			assign ch_start[p] = 1'h0;
			assign ch_cur[p] = 1'h0;
			assign ch_cont[p] = 1'h0;
			assign ch_fault[p] = 1'h0;
			assign bu_fire[p] = 1'h0;
			assign rt_fire[p] = 1'h0;
			assign ch_run[p] = 1'h0;
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					retrip_q[p] <= 1'h0;
				end else begin
					retrip_q[p] <= 1'h0; // RULE12
				end
			end
		end
	end

	wire logic any_bu_fire = |bu_fire;

	// Backup trip pulse
	bfp_pulse u_backup (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick_r),
		.i_kill(inhibit),
		.i_fire(any_bu_fire), // RULE9
		.i_pulse_ms(cfg_r.pulse_ms),
		.o_trip(o_backup_trip_out)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			running_r <= 1'h0;
		end else begin
			running_r <= |ch_run;
		end
	end

	assign o_phase1_retrip_out = retrip_q[0];
	assign o_phase2_retrip_out = retrip_q[1];
	assign o_phase3_retrip_out = retrip_q[2];
	assign o_ph_above = ph_above_r;
	assign o_res_above = res_above_r;
	assign o_running = running_r;
	assign o_cfg = cfg_r;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	tick_period_a: assert property (tick_r |=> !tick_r) // RULE18
		else $error("tick repeated");
	off_no_trip_a: assert property (cfg_r.mode == BFP_OFF |=> // RULE8
		!o_backup_trip_out && retrip_q == '0)
		else $error("trip while off");
	block_no_trip_a: assert property (i_block |=> // RULE13
		!o_backup_trip_out && retrip_q == '0)
		else $error("trip while blocked");
	common_no_retrip_a: assert property (!SINGLE_POLE |-> // RULE12
		retrip_q == '0)
		else $error("retrip in common variant");
	backup_follow_a: assert property ((|bu_fire) && !inhibit |=> // RULE9
		o_backup_trip_out)
		else $error("backup trip missing");
	retrip_gate_a: assert property ($rose(o_phase1_retrip_out) |-> // RULE11
		$past(cfg_r.retrip_en) && $past(rt_fire[0]))
		else $error("retrip without enable");
	cfg_range_a: assert property (cfg_r.backup_ms >= BFP_BACKUP_MIN && // RULE14
		cfg_r.backup_ms <= BFP_BACKUP_MAX &&
		cfg_r.retrip_ms <= BFP_RETRIP_MAX)
		else $error("delay setting out of range");
	thr_range_a: assert property (cfg_r.ph_thr >= BFP_PH_THR_MIN && // RULE16
		cfg_r.res_thr >= BFP_RES_THR_MIN && cfg_r.ph_thr <= BFP_THR_MAX)
		else $error("threshold out of range");
	current_only_a: assert property (cfg_r.mode == BFP_CURRENT |-> // RULE4
		ch_fault[0] == ch_cur[0])
		else $error("current mode fault wrong");
	contact_only_a: assert property (cfg_r.mode == BFP_CONTACT |-> // RULE5
		ch_fault[0] == ch_cont[0])
		else $error("contact mode fault wrong");
	both_reset_a: assert property (cfg_r.mode == BFP_BOTH && // RULE7
		ch_cont[0] |-> ch_fault[0])
		else $error("combined mode reset early");
	cfg_write_a: assert property (!i_cfg_wr |=> $stable(cfg_r)) // RULE3
		else $error("settings changed without write");
	common_retrip_off_a: assert property (!SINGLE_POLE |-> // RULE12
		!cfg_r.retrip_en)
		else $error("retrip enabled in common variant");
	inhibit_stop_a: assert property (inhibit |-> ##3 !running_r) // RULE13
		else $error("timer running while inhibited");
	backup_cause_a: assert property ($rose(o_backup_trip_out) |-> // RULE9
		$past(any_bu_fire))
		else $error("backup trip without timer expiry");

endmodule

// ### bfp_field.sv
// Far-side model: upstream start requests and breaker poles
module bfp_field import bfp_pkg::*; #(
	parameter int OPEN_CYC = 6
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Bench commands
	input wire logic [3:0] i_start_cmd,
	input wire logic [2:0] i_close_cmd,
	input wire logic [2:0] i_stuck,
	// Trips from the block
	input wire logic i_trip,
	input wire logic [2:0] i_retrip,
	// Towards the block
	output logic o_general_start,
	output logic [2:0] o_phase_start,
	output logic [2:0] o_pole_closed,
	output logic o_common_closed
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] open_r;
	int cnt_r [3];
	// Starts follow upstream trip commands
	assign o_general_start = i_start_cmd[3];
	assign o_phase_start = i_start_cmd[2:0];
	assign o_pole_closed = i_close_cmd & ~open_r;
	assign o_common_closed = |o_pole_closed;
	// Healthy pole opens a few cycles after a trip
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '{default: 0};
			open_r <= 3'h0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (!i_close_cmd[p]) begin
					cnt_r[p] <= 0;
					open_r[p] <= 1'b0;
				end else if ((i_trip || i_retrip[p]) && !i_stuck[p]) begin
					cnt_r[p] <= cnt_r[p] + 1;
					open_r[p] <= (cnt_r[p] >= OPEN_CYC - 1);
				end
			end
		end
	end
endmodule

// ### testbench.sv
// Self-checking bench of the breaker failure supervision block
module testbench import bfp_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = 4;
	logic i_clk = 0, i_rst_n = 0, i_cfg_wr = 0, res_st = 0, i_block = 0;
	bfp_cfg_t cfg = BFP_CFG_RST, ocfg, ocfg_cp;
	logic [3:0] st_cmd = 0;
	logic [2:0] cl_cmd = 0, stuck = 0, pst, pcl, rt, rt_cp, ph_above;
	logic [2:0][15:0] cur_ph = '0;
	logic [15:0] cur_res = 0, lfsr = 16'h0054;
	logic gst, ccl, bk, bk_cp, res_above, running;
	wire [3:0] trips = {bk, rt};
	int n_mismatch = 0, checks_done = 0, cyc_cnt = 0, t0 = 0;
	bit seen;

	bfp_field u_bfp_field (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_start_cmd(st_cmd), .i_close_cmd(cl_cmd), .i_stuck(stuck),
		.i_trip(bk), .i_retrip(rt), .o_general_start(gst),
		.o_phase_start(pst), .o_pole_closed(pcl), .o_common_closed(ccl));
	bfp_top #(.SINGLE_POLE(1'b1), .TICK_CYC(T)) u_bfp_top (.i_clk(i_clk),
		.i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr), .i_cfg(cfg),
		.i_general_start_request(gst), .i_phase1_start_request(pst[0]),
		.i_phase2_start_request(pst[1]), .i_phase3_start_request(pst[2]),
		.i_residual_start_request(res_st), .i_breaker_closed_common(ccl),
		.i_breaker_closed_phase1(pcl[0]), .i_breaker_closed_phase2(pcl[1]),
		.i_breaker_closed_phase3(pcl[2]), .i_block(i_block),
		.i_cur_ph(cur_ph), .i_cur_res(cur_res), .o_backup_trip_out(bk),
		.o_phase1_retrip_out(rt[0]), .o_phase2_retrip_out(rt[1]),
		.o_phase3_retrip_out(rt[2]), .o_ph_above(ph_above),
		.o_res_above(res_above), .o_running(running), .o_cfg(ocfg));
	bfp_top #(.SINGLE_POLE(1'b0), .TICK_CYC(T)) u_bfp_top_cp (.i_clk(i_clk),
		.i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr), .i_cfg(cfg),
		.i_general_start_request(gst), .i_phase1_start_request(pst[0]),
		.i_phase2_start_request(pst[1]), .i_phase3_start_request(pst[2]),
		.i_residual_start_request(res_st), .i_breaker_closed_common(ccl),
		.i_breaker_closed_phase1(pcl[0]), .i_breaker_closed_phase2(pcl[1]),
		.i_breaker_closed_phase3(pcl[2]), .i_block(i_block),
		.i_cur_ph(cur_ph), .i_cur_res(cur_res), .o_backup_trip_out(bk_cp),
		.o_phase1_retrip_out(rt_cp[0]), .o_phase2_retrip_out(rt_cp[1]),
		.o_phase3_retrip_out(rt_cp[2]), .o_ph_above(),
		.o_res_above(), .o_running(), .o_cfg(ocfg_cp));

	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) cyc_cnt++;

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	function automatic bit exp_trip(bfp_mode_t m, int src);
		return (m == BFP_CURRENT && src == 0) || m == BFP_BOTH ||
			(m == BFP_CONTACT && src != 0);
	endfunction
	task automatic chk(logic [$bits(bfp_cfg_t)-1:0] got,
		logic [$bits(bfp_cfg_t)-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic set_cfg();
		i_cfg_wr = 1;
		cyc(1);
		i_cfg_wr = 0;
		cyc(1);
	endtask
	task automatic wait_out(int sel, int lim);
		seen = 0;
		while (!seen && cyc_cnt - t0 < lim) begin
			cyc(1);
			seen = (trips[sel] === 1'b1);
		end
	endtask
	task automatic run_case(bfp_mode_t m, int src);
		int w;
		cfg.mode = m;
		set_cfg();
		cur_ph[1] = (src != 1) ? 16'h001F + rnd() % 50 : rnd() % 30;
		cur_res = rnd() % 20;
		cl_cmd = (src != 0) ? 3'h7 : 3'h0;
		stuck = 3'h7;
		cyc(2);
		st_cmd = 4'h8;
		t0 = cyc_cnt;
		if (src == 2) begin
			cyc(200);
			cur_ph[1] = 0;
		end
		wait_out(3, 101 * T + 10);
		chk(seen, exp_trip(m, src));
		chk(bk_cp, exp_trip(m, src));
		if (seen) begin
			w = cyc_cnt - t0;
			chk(w >= 99 * T && w <= 101 * T, 1);
			w = 0;
			while (bk === 1'b1 && w < 100) begin
				cyc(1);
				w++;
			end
			chk(w >= 2 * T && w <= 3 * T + 2, 1);
		end
		st_cmd = 0;
		cl_cmd = 0;
		cur_ph = '0;
		cyc(5);
	endtask
	task print_verdict();
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#(40 * 30000);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge i_clk);
		#1 i_rst_n = 1;
		chk(ocfg, BFP_CFG_RST);
		cfg = '{BFP_OFF, 1'h1, 8'h05, 8'hFA, 16'h07D0, 16'h0000, 16'hFFFF};
		set_cfg();
		chk(ocfg, {BFP_OFF, 1'h1, BFP_PH_THR_MIN, BFP_THR_MAX, BFP_RETRIP_MAX,
			BFP_BACKUP_MIN, BFP_PULSE_MAX});
		cfg = '{BFP_OFF, 1'h0, 8'h1E, 8'h14, 16'h0003, 16'h0064, 16'h0002};
		set_cfg();
		for (int i = 0; i < 20; i++) begin
			for (int k = 0; k < 3; k++)
				cur_ph[k] = (i == 0) ? 16'h001E : rnd() % 64;
			cur_res = (i == 0) ? 16'h0014 : rnd() % 48;
			cyc(1);
			for (int k = 0; k < 3; k++)
				chk(ph_above[k], cur_ph[k] > 30);
			chk(res_above, cur_res > 20);
		end
		cur_ph = '0;
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 3; s++)
				run_case(bfp_mode_t'(m), s);
		cfg.mode = BFP_CONTACT;
		cfg.retrip_en = 1;
		set_cfg();
		chk(ocfg_cp.retrip_en, 0);
		for (int s = 0; s < 2; s++) begin
			stuck = s ? 3'h2 : 3'h0;
			cl_cmd = 3'h2;
			cyc(2);
			st_cmd = 4'h2;
			t0 = cyc_cnt;
			wait_out(1, 5 * T + 4);
			chk(seen && cyc_cnt - t0 <= 4 * T + 3, 1);
			chk({rt[2], rt[0]}, 0);
			chk(rt_cp, 0);
			wait_out(3, 101 * T + 10);
			chk(seen, s);
			chk(bk_cp, s);
			st_cmd = 0;
			cl_cmd = 0;
			cyc(30);
		end
		cfg.mode = BFP_CURRENT;
		set_cfg();
		cur_ph[0] = 16'h0050;
		cyc(2);
		st_cmd = 4'h8;
		t0 = cyc_cnt;
		cyc(100);
		i_block = 1;
		cyc(3);
		chk(running, 0);
		wait_out(3, 101 * T + 10);
		chk(seen, 0);
		print_verdict();
	end
endmodule
